// ### verilog/cpr_panel.sv
// Purpose: Front panel keys, indicators, output routing and transfer output
// Assumes: Keys are raw pins, active high; function and source inputs share clk
// Notes: Read data stand only in the cycle after the read strobe
`timescale 1ns/1ns

// Key synchroniser and debouncer
module cpr_key
	import cpr_pkg::*;
#(
	parameter int DEB_CYC = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic level,
	output logic press,
	output logic rel
);
	logic sync_a;
	logic sync_b;
	logic [CNT_W-1:0] cnt;

	// Two-stage synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
		end
	end

	// New level taken once it has held for the debounce time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			level <= 1'b0;
			press <= 1'b0;
			rel <= 1'b0;
		end else begin
			press <= 1'b0;
			rel <= 1'b0;
			if (sync_b == level) begin
				cnt <= '0;
			end else if (cnt >= CNT_W'(DEB_CYC - 1)) begin
				cnt <= '0;
				level <= sync_b;
				press <= sync_b;
				rel <= ~sync_b;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule : cpr_key

// Panel decoding, indicators, output routing and transfer scaling
module cpr_panel
	import cpr_pkg::*;
#(
	parameter int LONG_CYC = LONG_PRESS_CYC,
	parameter int HOLD_CYC = POWER_HOLD_CYC,
	parameter int DEB_CYC = DEBOUNCE_CYC,
	parameter int FLASH_HALF = FLASH_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] keys,
	input wire cpr_fn_t fn,
	input wire logic tune_active,
	input wire cpr_src_t src,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic ctl_out_a,
	output logic ctl_out_b,
	output logic aux_out,
	output logic ctl_out_a_ind,
	output logic ctl_out_b_ind,
	output logic aux_out_ind,
	output logic hand_op_ind,
	output logic halt_ind,
	output logic far_op_ind,
	output logic self_tune_ind,
	output logic ctl_reset,
	output logic [2:0] input_sel,
	output logic [15:0] xfer_out
);
	logic rst_a;
	logic rst_n;
	logic [3:0] kl;
	logic [3:0] kp;
	logic [3:0] kr;
	logic [CNT_W-1:0] dur;
	logic long_hit;
	cpr_panel_t state;
	cpr_mode_t mode;
	cpr_mode_t pick;
	logic [3:0] pidx;
	logic [15:0] value;
	logic hand;
	logic stop;
	logic far;
	logic [1:0] in_type;
	cpr_asg_t asg;
	cpr_asg_t wasg;
	logic [2:0] xsel;
	logic [15:0] xlo;
	logic [15:0] xhi;
	logic [CNT_W-1:0] hcnt;
	logic hold;
	logic [CNT_W-1:0] fcnt;
	logic phase;
	logic off;
	logic [15:0] sel_val;
	logic signed [16:0] span;
	logic signed [33:0] prod;
	logic signed [17:0] res;
	logic [15:0] next_rdata;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	// One debouncer per key
	for (genvar k = 0; k < 4; k++) begin : g_key
		cpr_key #(.DEB_CYC(DEB_CYC)) u_key (
			.clk(clk),
			.rst_n(rst_n),
			.pin(keys[k]),
			.level(kl[k]),
			.press(kp[k]),
			.rel(kr[k])
		);
	end

	// Display key hold time, saturating at the threshold
	assign long_hit = dur >= CNT_W'(LONG_CYC);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dur <= '0;
		end else if (kp[KEY_DISP]) begin
			dur <= '0;
		end else if (kl[KEY_DISP] && !long_hit) begin
			dur <= dur + 1'b1;
		end
	end

	// Menu and parameter selection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PS_RUN;
			mode <= MD_LV0;
			pick <= MD_LV0;
			pidx <= '0;
		end else begin
			unique case (state)
				PS_RUN: begin
					if (kr[KEY_DISP] && long_hit) begin
						state <= PS_MENU;
						pick <= mode;
					end else if (kr[KEY_DISP]) begin
						pidx <= pidx + 1'b1;
					end
				end
				PS_MENU: begin
					if (kp[KEY_UP]) begin
						pick <= (pick == MD_CAL) ? MD_LV0 : cpr_mode_t'(3'(pick + 3'h1));
					end else if (kp[KEY_DN]) begin
						pick <= (pick == MD_LV0) ? MD_CAL : cpr_mode_t'(3'(pick - 3'h1));
					end else if (kr[KEY_DISP] && !long_hit) begin
						mode <= pick;
						state <= PS_RUN;
						pidx <= '0;
					end
				end
			endcase
		end
	end

	// Value on the second display, bus write first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= VALUE_RST;
		end else if (wr && addr == REG_VALUE) begin
			value <= wdata;
		end else if (state == PS_RUN && kp[KEY_UP]) begin
			value <= value + 16'h0001;
		end else if (state == PS_RUN && kp[KEY_DN]) begin
			value <= value - 16'h0001;
		end
	end

	// Auto and manual toggle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hand <= 1'b0;
		end else if (kp[KEY_AM]) begin
			hand <= ~hand;
		end
	end

	// Control register, undefined input type refused
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop <= 1'b0;
			far <= 1'b0;
			in_type <= IN_TEMP;
		end else if (wr && addr == REG_CTRL) begin
			stop <= wdata[CTRL_STOP];
			far <= wdata[CTRL_FAR];
			if (wdata[CTRL_IN+:2] != IN_BAD) begin
				in_type <= wdata[CTRL_IN+:2];
			end
		end
	end

	// Assignment write taken whole or refused whole
	assign wasg = cpr_asg_t'(wdata[9:0]);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			asg <= ASG_RST;
		end else if (wr && addr == REG_ASSIGN
			&& wasg.a <= FN_LBA && wasg.b <= FN_LBA
			&& wasg.aux >= FN_ALM1
			&& (!wasg.hc || wasg.a == FN_COOL || wasg.b == FN_COOL)) begin
			asg <= wasg;
		end
	end

	// Transfer source and limits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xsel <= XSEL_RST;
			xlo <= XLO_RST;
			xhi <= XHI_RST;
		end else if (wr) begin
			if (addr == REG_XSEL && wdata[2:0] <= SRC_CMV) begin
				xsel <= wdata[2:0];
			end
			if (addr == REG_XLO) begin
				xlo <= wdata;
			end
			if (addr == REG_XHI) begin
				xhi <= wdata;
			end
		end
	end

	// Power-on output hold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hcnt <= '0;
			hold <= 1'b1;
		end else if (hold) begin
			hcnt <= hcnt + 1'b1;
			hold <= hcnt < CNT_W'(HOLD_CYC - 1);
		end
	end

	// Control reset in setup-type modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reset <= 1'b0;
		end else begin
			unique case (mode)
				MD_LV0, MD_LV1, MD_LV2: ctl_reset <= 1'b0;
				MD_SETUP, MD_EXP, MD_OPT, MD_CAL: ctl_reset <= 1'b1;
				default: ctl_reset <= 1'b1;
			endcase
		end
	end

	// Pick the function for one output
	function automatic logic route(logic [2:0] code, cpr_fn_t f);
		logic r;
		r = 1'b0;
		unique case (code)
			FN_HEAT: r = f.heat;
			FN_COOL: r = f.cool;
			FN_ALM1: r = f.alarm[0];
			FN_ALM2: r = f.alarm[1];
			FN_ALM3: r = f.alarm[2];
			FN_LBA: r = f.loop_break_alarm;
			FN_INERR: r = f.in_err;
			FN_CVERR: r = f.conv_err;
		endcase
		return r;
	endfunction : route

	// Routed outputs, forced off by hold or control reset
	assign off = hold | ctl_reset;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_out_a <= 1'b0;
			ctl_out_b <= 1'b0;
			aux_out <= 1'b0;
		end else begin
			ctl_out_a <= !off && route(asg.a, fn);
			ctl_out_b <= !off && route(asg.b, fn);
			aux_out <= !off && route(asg.aux, fn);
		end
	end

	// Flash phase for the tuning indicator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fcnt <= '0;
			phase <= 1'b0;
		end else if (fcnt >= CNT_W'(FLASH_HALF - 1)) begin
			fcnt <= '0;
			phase <= ~phase;
		end else begin
			fcnt <= fcnt + 1'b1;
		end
	end

	// Indicators and input selection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_out_a_ind <= 1'b0;
			ctl_out_b_ind <= 1'b0;
			aux_out_ind <= 1'b0;
			hand_op_ind <= 1'b0;
			halt_ind <= 1'b0;
			far_op_ind <= 1'b0;
			self_tune_ind <= 1'b0;
			input_sel <= 3'h1;
		end else begin
			ctl_out_a_ind <= ctl_out_a;
			ctl_out_b_ind <= ctl_out_b;
			aux_out_ind <= aux_out;
			hand_op_ind <= hand;
			halt_ind <= stop;
			far_op_ind <= far;
			self_tune_ind <= tune_active && phase;
			input_sel <= 3'(3'h1 << in_type);
		end
	end

	// Transfer output, source stage then scaling stage
	assign span = $signed({1'b0, xhi}) - $signed({1'b0, xlo});
	assign prod = span * $signed({1'b0, sel_val});
	assign res = $signed({2'b00, xlo}) + prod[33:16];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_val <= 16'h0000;
			xfer_out <= 16'h0000;
		end else begin
			unique case (xsel)
				SRC_RAMP: sel_val <= src.ramp_target;
				SRC_PV: sel_val <= src.pv;
				SRC_HMV: sel_val <= src.heat_mv;
				SRC_CMV: sel_val <= src.cool_mv;
				default: sel_val <= src.target_value;
			endcase
			xfer_out <= res[15:0];
		end
	end

	// Register read mux
	always_comb begin
		next_rdata = 16'h0000;
		unique case (addr)
			REG_CTRL: next_rdata = {12'h000, in_type, far, stop};
			REG_ASSIGN: next_rdata = {6'h00, asg};
			REG_XSEL: next_rdata = {13'h0000, xsel};
			REG_XLO: next_rdata = xlo;
			REG_XHI: next_rdata = xhi;
			REG_STAT: next_rdata = {6'h00, hold, ctl_reset, state, mode, hand,
				aux_out, ctl_out_b, ctl_out_a};
			REG_PANEL: next_rdata = {9'h000, pick, pidx};
			REG_VALUE: next_rdata = value;
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data for one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= rd ? next_rdata : 16'h0000;
		end
	end

	// Checks on the logic above
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	am_toggle_a: assert property (kp[KEY_AM] |=> hand != $past(hand))
		else $error("A/M press did not toggle");
	short_adv_a: assert property (state == PS_RUN && kr[KEY_DISP] && !long_hit
		|=> pidx == 4'($past(pidx) + 4'h1)) else $error("short press did not advance");
	menu_open_a: assert property (state == PS_RUN && kr[KEY_DISP] && long_hit
		|=> state == PS_MENU && pick == $past(mode)) else $error("menu did not open");
	up_step_a: assert property (state == PS_RUN && kp[KEY_UP] && !(wr && addr == REG_VALUE)
		|=> value == 16'($past(value) + 16'h0001)) else $error("up did not step");
	down_step_a: assert property (state == PS_RUN && kp[KEY_DN] && !(wr && addr == REG_VALUE)
		|=> value == 16'($past(value) - 16'h0001)) else $error("down did not step");
	out_ind_a: assert property (ctl_out_a_ind == $past(ctl_out_a) && ctl_out_b_ind == $past(ctl_out_b))
		else $error("output indicator not lit");
	aux_ind_a: assert property (aux_out |=> aux_out_ind)
		else $error("aux indicator not lit");
	hand_ind_a: assert property (hand_op_ind == $past(hand))
		else $error("manual indicator not lit");
	power_hold_a: assert property (hold |-> !ctl_out_a && !ctl_out_b && !aux_out)
		else $error("output on during power hold");
	input_one_a: assert property ($onehot(input_sel))
		else $error("input selection not one-hot");
	ctl_fn_a: assert property (asg.a <= FN_LBA && asg.b <= FN_LBA)
		else $error("illegal control output function");
	aux_fn_a: assert property (asg.aux >= FN_ALM1)
		else $error("illegal aux output function");
	hc_cool_a: assert property (asg.hc |-> asg.a == FN_COOL || asg.b == FN_COOL)
		else $error("cool not routed in heat-cool");
	xsel_ok_a: assert property (xsel <= SRC_CMV)
		else $error("illegal transfer source");
	scale_flat_a: assert property ((xlo == xhi && $stable(xlo)) [*2] |-> xfer_out == xlo)
		else $error("flat scaling not at limit");
	reset_off_a: assert property (ctl_reset |=> !ctl_out_a && !ctl_out_b && !aux_out)
		else $error("output on during control reset");
	dur_zero_a: assert property (kp[KEY_DISP] |=> dur == '0)
		else $error("press counter not restarted");
endmodule : cpr_panel

// ### shared/cpr_pkg.sv
// Purpose: Constants and types of the panel and output routing block
// Assumes: 10 MHz clock, keys active high, sixteen-bit register port
// Notes: Times are kept in ms, cycle counts derive from the clock rate
// Behaviour
// - A/M key press toggles auto and manual
// - Short display press advances to next parameter
// - Long display press opens the mode menu
// - Up key press steps shown value up
// - Down key press steps shown value down
// - Control output indicators follow their outputs
// - Aux indicator follows its output
// - Manual indicator lit during manual operation
// - Halted indicator lit while control stopped
// - Remote indicator lit during remote operation
// - Tuning indicator flashes while auto-tuning
// - Control and aux outputs held off five seconds after power
// - Exactly one input type active
// - Control outputs take heat, cool, alarms, loop break
// - Aux output takes alarms, loop break, errors
// - Heat-cool operation routes cool to a control output
// - Transfer output carries one of five sources
// - Transfer scaling between limits, inverted allowed
// - Setup-type modes reset control, outputs off
package cpr_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int LONG_PRESS_MS = 1000;
	localparam int POWER_HOLD_MS = 5000;
	localparam int DEBOUNCE_MS = 20;
	localparam int FLASH_MS = 500;
	localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
	localparam int POWER_HOLD_CYC = POWER_HOLD_MS * CYC_PER_MS;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int FLASH_CYC = FLASH_MS * CYC_PER_MS;
	localparam int CNT_W = 26;
	// Register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ASSIGN = 4'h1;
	localparam logic [3:0] REG_XSEL = 4'h2;
	localparam logic [3:0] REG_XLO = 4'h3;
	localparam logic [3:0] REG_XHI = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h5;
	localparam logic [3:0] REG_PANEL = 4'h6;
	localparam logic [3:0] REG_VALUE = 4'h7;
	// Control register fields
	localparam int CTRL_STOP = 0;
	localparam int CTRL_FAR = 1;
	localparam int CTRL_IN = 2;
	localparam logic [1:0] IN_TEMP = 2'h0;
	localparam logic [1:0] IN_VOLT = 2'h1;
	localparam logic [1:0] IN_CURR = 2'h2;
	localparam logic [1:0] IN_BAD = 2'h3;
	// Key positions in the key vector
	localparam int KEY_AM = 0;
	localparam int KEY_DISP = 1;
	localparam int KEY_UP = 2;
	localparam int KEY_DN = 3;
	// Output function codes
	localparam logic [2:0] FN_HEAT = 3'h0;
	localparam logic [2:0] FN_COOL = 3'h1;
	localparam logic [2:0] FN_ALM1 = 3'h2;
	localparam logic [2:0] FN_ALM2 = 3'h3;
	localparam logic [2:0] FN_ALM3 = 3'h4;
	localparam logic [2:0] FN_LBA = 3'h5;
	localparam logic [2:0] FN_INERR = 3'h6;
	localparam logic [2:0] FN_CVERR = 3'h7;
	// Transfer source codes
	localparam logic [2:0] SRC_TV = 3'h0;
	localparam logic [2:0] SRC_RAMP = 3'h1;
	localparam logic [2:0] SRC_PV = 3'h2;
	localparam logic [2:0] SRC_HMV = 3'h3;
	localparam logic [2:0] SRC_CMV = 3'h4;
	typedef struct packed {
		logic hc;
		logic [2:0] aux;
		logic [2:0] b;
		logic [2:0] a;
	} cpr_asg_t;
	typedef struct packed {
		logic conv_err;
		logic in_err;
		logic loop_break_alarm;
		logic [2:0] alarm;
		logic cool;
		logic heat;
	} cpr_fn_t;
	typedef struct packed {
		logic [15:0] cool_mv;
		logic [15:0] heat_mv;
		logic [15:0] pv;
		logic [15:0] ramp_target;
		logic [15:0] target_value;
	} cpr_src_t;
	typedef enum logic [2:0] {MD_LV0, MD_LV1, MD_LV2, MD_SETUP, MD_EXP, MD_OPT, MD_CAL} cpr_mode_t;
	typedef enum logic {PS_RUN, PS_MENU} cpr_panel_t;
	// Values after reset
	localparam cpr_asg_t ASG_RST = '{hc: 1'b0, aux: FN_ALM2, b: FN_ALM1, a: FN_HEAT};
	localparam logic [2:0] XSEL_RST = SRC_TV;
	localparam logic [15:0] XLO_RST = 16'h0000;
	localparam logic [15:0] XHI_RST = 16'hffff;
	localparam logic [15:0] VALUE_RST = 16'h0000;
endpackage : cpr_pkg

// ### testbench/cpr_keypad.sv
// Purpose: Front panel key model that presses one key for a given time
// Assumes: Keys are active high and fall back low when let go
// Notes: Press length is counted in clock cycles at the pin
`timescale 1ns/1ns

module cpr_keypad (
	input wire logic clk,
	output logic [3:0] keys
);
	initial begin
		keys = 4'h0;
	end

	// Hold one key for n cycles, then let it go and allow settling
	task automatic press(input int idx, input int n);
		@(posedge clk);
		keys[idx] <= 1'b1;
		repeat (n) @(posedge clk);
		keys[idx] <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
	endtask : press
endmodule : cpr_keypad

// ### testbench/tb_cpr_panel.sv
// Purpose: Self-checking bench of the panel and output routing block
// Assumes: Shortened counts: long press 20, hold 30, debounce 2, flash 4
// Notes: Keys come from the keypad model, registers from bus tasks here
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end

module tb_cpr_panel;
	import cpr_pkg::*;
	logic clk, rstn, tune_active, wr, rd;
	logic [3:0] keys, addr;
	logic [15:0] wdata, rdata, xfer_out, d;
	cpr_fn_t fn;
	cpr_src_t src;
	logic oa, ob, ox, ia, ib, ix, hand, halt, far, tune, creset;
	logic [2:0] input_sel;
	int errors = 0;
	int n_compared = 0;

	cpr_keypad u_cpr_keypad (.clk(clk), .keys(keys));

	cpr_panel #(.LONG_CYC(20), .HOLD_CYC(30), .DEB_CYC(2), .FLASH_HALF(4)) u_cpr_panel (
		.clk(clk), .rstn(rstn), .keys(keys), .fn(fn), .tune_active(tune_active),
		.src(src), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ctl_out_a(oa), .ctl_out_b(ob), .aux_out(ox), .ctl_out_a_ind(ia),
		.ctl_out_b_ind(ib), .aux_out_ind(ix), .hand_op_ind(hand), .halt_ind(halt),
		.far_op_ind(far), .self_tune_ind(tune), .ctl_reset(creset),
		.input_sel(input_sel), .xfer_out(xfer_out));

	// Clock of 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic settle();
		repeat (5) @(posedge clk);
		#1;
	endtask : settle

	// Outputs stay off through the power-on hold, then follow their functions
	task automatic t_hold();
		repeat (10) @(posedge clk);
		#1 `CHK("hold_a", 1'b0, oa)
		`CHK("hold_x", 1'b0, ox)
		repeat (35) @(posedge clk);
		#1 `CHK("rel_a", 1'b1, oa)
		`CHK("rel_x", 1'b1, ox)
		`CHK("ind_a", 1'b1, ia)
		`CHK("ind_b", 1'b0, ib)
		`CHK("ind_x", 1'b1, ix)
	endtask : t_hold

	task automatic t_reset_vals();
		rd_reg(REG_CTRL);
		`CHK("ctrl_rst", 16'h0000, d)
		rd_reg(REG_ASSIGN);
		`CHK("asg_rst", 16'h00d0, d)
		rd_reg(REG_XHI);
		`CHK("xhi_rst", 16'hffff, d)
		rd_reg(4'h8);
		`CHK("unmapped", 16'h0000, d)
		`CHK("in_rst", 3'b001, input_sel)
	endtask : t_reset_vals

	// Every legal code routed to each output, illegal ones refused
	task automatic t_route();
		for (int c = 0; c < 8; c++) begin
			if (c < 6) wr_reg(REG_ASSIGN, 16'(((c < 2 ? 2 : c) << 6) | (c << 3) | c));
			else wr_reg(REG_ASSIGN, 16'((c << 6) | 2));
			fn <= cpr_fn_t'(8'h01 << c);
			settle();
			if (c < 6) `CHK("route_a", 1'b1, oa)
			if (c < 6) `CHK("route_b", 1'b1, ob)
			if (c >= 2) `CHK("route_x", 1'b1, ox)
		end
		wr_reg(REG_ASSIGN, 16'h0006);
		rd_reg(REG_ASSIGN);
		`CHK("asg_bad_a", 16'h01c2, d)
		wr_reg(REG_ASSIGN, 16'h0048);
		rd_reg(REG_ASSIGN);
		`CHK("asg_bad_x", 16'h01c2, d)
		wr_reg(REG_ASSIGN, 16'h0290);
		rd_reg(REG_ASSIGN);
		`CHK("hc_nocool", 16'h01c2, d)
		wr_reg(REG_ASSIGN, 16'h0288);
		rd_reg(REG_ASSIGN);
		`CHK("hc_cool_b", 16'h0288, d)
		wr_reg(REG_ASSIGN, 16'h00d0);
		fn <= cpr_fn_t'(8'h01);
	endtask : t_route

	task automatic t_manual();
		u_cpr_keypad.press(KEY_AM, 6);
		`CHK("manual_on", 1'b1, hand)
		rd_reg(REG_STAT);
		`CHK("stat_man", 1'b1, d[3])
		u_cpr_keypad.press(KEY_AM, 6);
		`CHK("manual_off", 1'b0, hand)
	endtask : t_manual

	// Short press steps the parameter, long press opens the menu
	task automatic t_menu();
		logic [3:0] p0;
		rd_reg(REG_PANEL);
		p0 = d[3:0];
		u_cpr_keypad.press(KEY_DISP, 6);
		rd_reg(REG_PANEL);
		`CHK("param_step", p0 + 4'h1, d[3:0])
		u_cpr_keypad.press(KEY_DISP, 40);
		rd_reg(REG_STAT);
		`CHK("menu_open", 1'b1, d[7])
		repeat (3) u_cpr_keypad.press(KEY_UP, 6);
		rd_reg(REG_PANEL);
		`CHK("pick_setup", 3'h3, d[6:4])
		u_cpr_keypad.press(KEY_DISP, 6);
		rd_reg(REG_STAT);
		`CHK("mode_setup", 4'h3, d[7:4])
		`CHK("ctl_rst_on", 1'b1, creset)
		`CHK("setup_off", 1'b0, oa)
		u_cpr_keypad.press(KEY_DISP, 40);
		repeat (3) u_cpr_keypad.press(KEY_DN, 6);
		u_cpr_keypad.press(KEY_DISP, 6);
		`CHK("ctl_rst_off", 1'b0, creset)
		`CHK("resume_a", 1'b1, oa)
	endtask : t_menu

	task automatic t_value();
		wr_reg(REG_VALUE, 16'hffff);
		u_cpr_keypad.press(KEY_UP, 6);
		rd_reg(REG_VALUE);
		`CHK("val_up", 16'h0000, d)
		repeat (2) u_cpr_keypad.press(KEY_DN, 6);
		rd_reg(REG_VALUE);
		`CHK("val_dn", 16'hfffe, d)
	endtask : t_value

	task automatic t_ctrl();
		wr_reg(REG_CTRL, 16'h000b);
		settle();
		`CHK("halt", 1'b1, halt)
		`CHK("far", 1'b1, far)
		`CHK("in_curr", 3'b100, input_sel)
		wr_reg(REG_CTRL, 16'h000c);
		settle();
		`CHK("in_bad", 3'b100, input_sel)
		`CHK("halt_off", 1'b0, halt)
		wr_reg(REG_CTRL, 16'h0004);
		settle();
		`CHK("in_volt", 3'b010, input_sel)
	endtask : t_ctrl

	task automatic t_tune();
		logic [7:0] ones;
		ones = 8'h00;
		@(posedge clk);
		tune_active <= 1'b1;
		repeat (24) begin
			@(posedge clk);
			#1 ones = ones + 8'(tune);
		end
		`CHK("tune_flash", 8'h0c, ones)
		@(posedge clk);
		tune_active <= 1'b0;
		settle();
		`CHK("tune_idle", 1'b0, tune)
	endtask : t_tune

	// Each source scaled forward and reversed
	task automatic t_xfer();
		logic [15:0] s;
		for (int i = 0; i < 5; i++) begin
			s = src[16*i +: 16];
			wr_reg(REG_XSEL, 16'(i));
			wr_reg(REG_XLO, 16'h0000);
			wr_reg(REG_XHI, 16'h8000);
			settle();
			`CHK("xfer_fwd", s >> 1, xfer_out)
			wr_reg(REG_XLO, 16'h8000);
			wr_reg(REG_XHI, 16'h0000);
			settle();
			`CHK("xfer_rev", 16'h8000 - (s >> 1), xfer_out)
		end
		wr_reg(REG_XLO, 16'h1234);
		wr_reg(REG_XHI, 16'h1234);
		settle();
		`CHK("xfer_flat", 16'h1234, xfer_out)
		wr_reg(REG_XSEL, 16'h0005);
		rd_reg(REG_XSEL);
		`CHK("xsel_bad", 16'h0004, d)
	endtask : t_xfer

	task automatic final_report();
		$display("errors %0d n_compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// Watchdog well beyond the expected run
	initial begin
		#3_000_000;
		errors++;
		final_report();
	end

	initial begin
		rstn = 1'b0;
		tune_active = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		fn = cpr_fn_t'(8'h09);
		src = '{cool_mv: 16'hc000, heat_mv: 16'h8000, pv: 16'h4000,
			ramp_target: 16'h2000, target_value: 16'h1000};
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_hold();
		t_reset_vals();
		t_route();
		t_manual();
		t_menu();
		t_value();
		t_ctrl();
		t_tune();
		t_xfer();
		final_report();
	end
endmodule : tb_cpr_panel
